// ---- design/phy_status_defines.vh ----
// Constants for the quick status and interrupt enable register bank
`ifndef PHY_STATUS_DEFINES_VH
`define PHY_STATUS_DEFINES_VH

// ==========================================
// Register bus geometry
`define ADDR_W            5
`define DATA_W            16

// ==========================================
// Register offsets (register index on the management port)
`define OFF_QUICK_STATUS  5'h11
`define OFF_IRQ_ENABLE    5'h12
`define OFF_EVENT_STATUS  5'h13

// ==========================================
// Quick status field positions
`define QS_RATE_HI        15
`define QS_RATE_LO        14
`define QS_DUPLEX         13
`define QS_PAGE           12
`define QS_RESOLVED       11
`define QS_LINK           10
`define QS_XOVER_CD       9
`define QS_XOVER_AB       8
`define QS_FALLBACK       7
`define QS_SLEEP          6
`define QS_POL_HI         5
`define QS_POL_LO         2
`define QS_POL10          1
`define QS_JABBER         0

// ==========================================
// Event bit positions, shared by enable and event status words
`define EV_NEG_ERROR      15
`define EV_RATE           14
`define EV_DUPLEX         13
`define EV_PAGE           12
`define EV_NEG_DONE       11
`define EV_LINK           10
`define EV_FALSE_CARRIER  8
`define EV_XOVER          6
`define EV_FALLBACK       5
`define EV_SLEEP          4
`define EV_WAKE           3
`define EV_MAC_IF         2
`define EV_POLARITY       1
`define EV_JABBER         0

// ==========================================
// Reset values and masks
`define QS_RESET          16'h0002
`define EN_RESET          16'h0000
`define EV_RESET          16'h0000
`define EN_WMASK          16'hFD7F
`define ZERO_WORD         16'h0000

`endif

// ---- design/sticky_event_bits.v ----
// Sticky event flags: set by hardware, cleared by writing a one, set wins
`timescale 1ns/1ps

module sticky_event_bits #(
  parameter W = 16
) (
  input  wire         sys_clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] set_i,
  input  wire [W-1:0] clr_i,
  output wire [W-1:0] q_o
);

  // ==========================================
  // One flop per flag
  reg [W-1:0] flag_ff;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_flag
      always @(posedge sys_clk_i) begin
        if (rst_i) begin
          flag_ff[g] <= 1'b0;
        end else if (set_i[g]) begin
          // A new event in the clearing cycle is kept
          flag_ff[g] <= 1'b1;
        end else if (clr_i[g]) begin
          flag_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign q_o = flag_ff;

endmodule // sticky_event_bits

// ---- design/phy_status_and_irq_enable.v ----
// Quick status word, interrupt enable word and event status of the transceiver
// Function
// - Bits 15:14 give speed 00/01/10, 11 reserved; bit 13 full duplex.
// - Bit 12 latches on page arrival, clears when status word is read.
// - Bit 11 is one when negotiation done or disabled, else zero.
// - Bits 9 and 8 give crossover for C/D and A/B pairs.
// - Bit 6 is one while the transceiver sleeps.
// - Bits 5:2 give polarity of channels D,C,B,A, one means reversed.
// - Bit 1 gives 10 Mbps polarity, one correct, resets to one.
// - Bit 0 mirrors jabber detect and does not clear on read.
// - Interrupt raised for an event only if its enable bit is set.
// - Enables for negotiation error, speed, duplex, page at 15..12, reset zero.
// - Enables for negotiation done, link, false carrier at 11,10,8, reset zero.
// - Enables for crossover, fallback, sleep, wake at 6,5,4,3, reset zero.
// - Enables for media-interface error, polarity, jabber at 2,1,0, reset zero.
// - Event status latches every event regardless of its enable.
`timescale 1ns/1ps
`include "phy_status_defines.vh"

module phy_status_and_irq_enable (
  input  wire                 sys_clk_i,
  input  wire                 rst_i,
  // Register port
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [`DATA_W-1:0]   wdata_i,
  input  wire                 wr_i,
  input  wire                 rd_i,
  output wire [`DATA_W-1:0]   rdata_o,
  output wire                 irq_o,
  // Line state from the datapath
  input  wire [1:0]           resolved_rate_i,
  input  wire                 full_duplex_i,
  input  wire                 page_rx_i,
  input  wire                 neg_enabled_i,
  input  wire                 neg_complete_i,
  input  wire                 link_up_i,
  input  wire                 crossover_pairs_cd_i,
  input  wire                 crossover_pairs_ab_i,
  input  wire                 fallback_active_i,
  input  wire                 sleep_i,
  input  wire [3:0]           channel_polarity_reversed_i,
  input  wire                 pol10_correct_i,
  input  wire                 jabber_i,
  // One-cycle event pulses from the datapath
  input  wire                 neg_error_i,
  input  wire                 false_carrier_i,
  input  wire                 fallback_event_i,
  input  wire                 wake_packet_i,
  input  wire                 mac_if_error_i
);

  // ==========================================
  // Address decode
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire rd_qs = rd_i & hit(addr_i, `OFF_QUICK_STATUS);
  wire rd_en = rd_i & hit(addr_i, `OFF_IRQ_ENABLE);
  wire rd_ev = rd_i & hit(addr_i, `OFF_EVENT_STATUS);
  wire wr_en = wr_i & hit(addr_i, `OFF_IRQ_ENABLE);
  wire wr_ev = wr_i & hit(addr_i, `OFF_EVENT_STATUS);

  // ==========================================
  // State
  reg  [`DATA_W-1:0] qs_ff;
  reg  [`DATA_W-1:0] nxt_qs;
  reg  [`DATA_W-1:0] en_ff;
  reg  [`DATA_W-1:0] rdata_ff;
  reg  [`DATA_W-1:0] nxt_rdata;
  reg                irq_ff;
  reg                primed_ff;
  reg  [`DATA_W-1:0] ev_set;
  wire [`DATA_W-1:0] ev_q;
  wire [`DATA_W-1:0] ev_clr;
  wire               resolved_now;

  // ==========================================
  // Quick status sampling
  assign resolved_now = neg_complete_i | ~neg_enabled_i;

  always @* begin
    nxt_qs                          = qs_ff;
    nxt_qs[`QS_RATE_HI:`QS_RATE_LO] = resolved_rate_i;
    nxt_qs[`QS_DUPLEX]              = full_duplex_i;
    nxt_qs[`QS_RESOLVED]            = resolved_now;
    nxt_qs[`QS_LINK]                = link_up_i;
    nxt_qs[`QS_XOVER_CD]            = crossover_pairs_cd_i;
    nxt_qs[`QS_XOVER_AB]            = crossover_pairs_ab_i;
    nxt_qs[`QS_FALLBACK]            = fallback_active_i;
    nxt_qs[`QS_SLEEP]               = sleep_i;
    nxt_qs[`QS_POL_HI:`QS_POL_LO]   = channel_polarity_reversed_i;
    nxt_qs[`QS_POL10]               = pol10_correct_i;
    nxt_qs[`QS_JABBER]              = jabber_i;
    // Page flag: arrival wins over the clearing read
    if (page_rx_i) begin
      nxt_qs[`QS_PAGE] = 1'b1;
    end else if (rd_qs) begin
      nxt_qs[`QS_PAGE] = 1'b0;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      qs_ff <= `QS_RESET;
    end else begin
      qs_ff <= nxt_qs;
    end
  end

  // ==========================================
  // Event detection
  // Change events compare against last cycle's sample; the first cycle after
  // reset is skipped so reset values do not look like changes.
  always @* begin
    ev_set                    = `ZERO_WORD;
    ev_set[`EV_NEG_ERROR]     = neg_error_i;
    ev_set[`EV_RATE]          = resolved_rate_i != qs_ff[`QS_RATE_HI:`QS_RATE_LO];
    ev_set[`EV_DUPLEX]        = full_duplex_i != qs_ff[`QS_DUPLEX];
    ev_set[`EV_PAGE]          = page_rx_i;
    ev_set[`EV_NEG_DONE]      = resolved_now & ~qs_ff[`QS_RESOLVED];
    ev_set[`EV_LINK]          = link_up_i != qs_ff[`QS_LINK];
    ev_set[`EV_FALSE_CARRIER] = false_carrier_i;
    ev_set[`EV_XOVER]         = (crossover_pairs_cd_i != qs_ff[`QS_XOVER_CD]) |
                                (crossover_pairs_ab_i != qs_ff[`QS_XOVER_AB]);
    ev_set[`EV_FALLBACK]      = fallback_event_i;
    ev_set[`EV_SLEEP]         = sleep_i != qs_ff[`QS_SLEEP];
    ev_set[`EV_WAKE]          = wake_packet_i;
    ev_set[`EV_MAC_IF]        = mac_if_error_i;
    ev_set[`EV_POLARITY]      = (pol10_correct_i != qs_ff[`QS_POL10]) |
                                (channel_polarity_reversed_i != qs_ff[`QS_POL_HI:`QS_POL_LO]);
    ev_set[`EV_JABBER]        = jabber_i & ~qs_ff[`QS_JABBER];
    if (!primed_ff) begin
      ev_set = `ZERO_WORD;
      ev_set[`EV_NEG_ERROR]     = neg_error_i;
      ev_set[`EV_PAGE]          = page_rx_i;
      ev_set[`EV_FALSE_CARRIER] = false_carrier_i;
      ev_set[`EV_FALLBACK]      = fallback_event_i;
      ev_set[`EV_WAKE]          = wake_packet_i;
      ev_set[`EV_MAC_IF]        = mac_if_error_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      primed_ff <= 1'b0;
    end else begin
      primed_ff <= 1'b1;
    end
  end

  // ==========================================
  // Event status, latched independent of enables
  assign ev_clr = wr_ev ? wdata_i : `ZERO_WORD;

  sticky_event_bits #(
    .W (`DATA_W)
  ) u_events (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (ev_set & `EN_WMASK),
    .clr_i     (ev_clr),
    .q_o       (ev_q)
  );

  // ==========================================
  // Interrupt enable word
  // Reserved bits are masked on write so they always read zero.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      en_ff <= `EN_RESET;
    end else if (wr_en) begin
      en_ff <= wdata_i & `EN_WMASK;
    end
  end

  // ==========================================
  // Interrupt output
  // Uses next-state values so the pin follows status without an extra lag.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((ev_q & ~ev_clr) | (ev_set & `EN_WMASK)) &
                  (wr_en ? (wdata_i & `EN_WMASK) : en_ff));
    end
  end

  // ==========================================
  // Read data, valid only in the cycle after the strobe
  always @* begin
    nxt_rdata = `ZERO_WORD;
    if (rd_qs) begin
      nxt_rdata = qs_ff;
    end else if (rd_en) begin
      nxt_rdata = en_ff;
    end else if (rd_ev) begin
      nxt_rdata = ev_q;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_ff <= `ZERO_WORD;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign irq_o   = irq_ff;

endmodule // phy_status_and_irq_enable

// ---- verif/mgmt_host_model.sv ----
// Management host model driving the register port
`timescale 1ns/1ps

module mgmt_host_model (
  input  wire        sys_clk_i,
  input  wire [15:0] rdata_i,
  output reg  [4:0]  addr_o,
  output reg  [15:0] wdata_o,
  output reg         wr_o,
  output reg         rd_o
);
  initial begin
    addr_o  = 5'h00;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // ==========================================
  // Accesses; callers enter just after a rising edge
  // Two writes may not follow with no edge between, the strobe would be set twice
  task wr_reg(input [4:0] a, input [15:0] d);
    begin
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge sys_clk_i);
      wr_o    <= 1'b0;
    end
  endtask
  task rd_reg(input [4:0] a, output [15:0] d);
    begin
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge sys_clk_i);
      rd_o   <= 1'b0;
      @(posedge sys_clk_i);
      d = rdata_i;
    end
  endtask
  // Back-to-back reads; the data is judged by the checker only
  task rd_burst(input [4:0] a, input integer n);
    begin
      addr_o <= a;
      rd_o   <= 1'b1;
      repeat (n) @(posedge sys_clk_i);
      rd_o   <= 1'b0;
    end
  endtask
endmodule // mgmt_host_model

// ---- verif/phy_status_checker.sv ----
// Checker for the quick status and interrupt enable bank
`timescale 1ns/1ps

module phy_status_checker (
  input logic        sys_clk_i,
  input logic        rst_i,
  input logic [4:0]  addr_i,
  input logic [15:0] wdata_i,
  input logic        wr_i,
  input logic        rd_i,
  input logic [15:0] rdata_o,
  input logic        irq_o,
  input logic [1:0]  resolved_rate_i,
  input logic        full_duplex_i,
  input logic        page_rx_i,
  input logic        neg_enabled_i,
  input logic        neg_complete_i,
  input logic        link_up_i,
  input logic        crossover_pairs_cd_i,
  input logic        crossover_pairs_ab_i,
  input logic        fallback_active_i,
  input logic        sleep_i,
  input logic [3:0]  channel_polarity_reversed_i,
  input logic        pol10_correct_i,
  input logic        jabber_i
);
  // ==========================================
  // Expected status word; bit 12 is latched and judged apart
  wire [15:0] exp_qs = {resolved_rate_i, full_duplex_i, 1'b0, neg_complete_i | ~neg_enabled_i, link_up_i,
    crossover_pairs_cd_i, crossover_pairs_ab_i, fallback_active_i, sleep_i, channel_polarity_reversed_i,
    pol10_correct_i, jabber_i};
  wire        rd_qs  = rd_i && addr_i == 5'h11;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Assertions; status lags its inputs by one sample
  a_rate_duplex: assert property (rd_qs && !$past(rst_i) |=> rdata_o[15:13] == $past(exp_qs[15:13], 2))
    else $error("rate or duplex field wrong");
  a_page_set: assert property (page_rx_i && !$past(rst_i) ##1 rd_qs |=> rdata_o[12])
    else $error("page bit not latched");
  a_page_clear: assert property (rd_qs && !page_rx_i ##1 rd_qs |=> !rdata_o[12])
    else $error("page bit not cleared by read");
  a_resolved_bit: assert property (rd_qs && !$past(rst_i) |=> rdata_o[11] == $past(exp_qs[11], 2))
    else $error("resolved bit wrong");
  a_link_xover: assert property (rd_qs && !$past(rst_i) |=> rdata_o[10:8] == $past(exp_qs[10:8], 2))
    else $error("link or crossover bits wrong");
  a_fallback_sleep: assert property (rd_qs && !$past(rst_i) |=> rdata_o[7:6] == $past(exp_qs[7:6], 2))
    else $error("fallback or sleep bit wrong");
  a_polarity_jabber: assert property (rd_qs && !$past(rst_i) |=> rdata_o[5:0] == $past(exp_qs[5:0], 2))
    else $error("polarity or jabber bits wrong");
  a_irq_masked: assert property ($past(wr_i && addr_i == 5'h12 && wdata_i == 16'h0000) |-> !irq_o)
    else $error("interrupt with all enables off");
  a_en_readback: assert property (wr_i && addr_i == 5'h12 ##1 rd_i && addr_i == 5'h12
    |=> rdata_o == ($past(wdata_i, 2) & 16'hFD7F))
    else $error("enable word read back wrong");
  c_status_read: cover property (rd_qs);
  c_irq_high: cover property (irq_o);
  c_page_seen: cover property (rd_qs ##1 rdata_o[12]);
endmodule // phy_status_checker

bind phy_status_and_irq_enable phy_status_checker i_chk (.*);

// ---- verif/phy_status_and_irq_enable_tb.sv ----
// Testbench for the quick status and interrupt enable bank
`timescale 1ns/1ps

module phy_status_and_irq_enable_tb;
  logic        clk, rst, wr, rd, irq, page;
  logic [4:0]  addr, ev;
  logic [15:0] wdata, rdata, ls, rv;
  integer      err_total, checks_done, cyc, i, b;
  logic [13:0] pat [0:3] = '{14'h1555, 14'h0000, 14'h2AAA, 14'h3FFF};
  int          eb [0:4] = '{15, 8, 5, 3, 2};

  phy_status_and_irq_enable i_dut (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .resolved_rate_i(ls[15:14]), .full_duplex_i(ls[13]),
    .page_rx_i(page), .neg_enabled_i(ls[12]), .neg_complete_i(ls[11]), .link_up_i(ls[10]),
    .crossover_pairs_cd_i(ls[9]), .crossover_pairs_ab_i(ls[8]), .fallback_active_i(ls[7]), .sleep_i(ls[6]),
    .channel_polarity_reversed_i(ls[5:2]), .pol10_correct_i(ls[1]), .jabber_i(ls[0]), .neg_error_i(ev[0]),
    .false_carrier_i(ev[1]), .fallback_event_i(ev[2]), .wake_packet_i(ev[3]), .mac_if_error_i(ev[4]));
  mgmt_host_model i_host (.sys_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  // ==========================================
  // Clock, timeout and helpers
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  function logic [15:0] qs(input logic [15:0] l);
    qs = {l[15:13], 1'b0, l[11] | ~l[12], l[10:0]};
  endfunction
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // Judged at the falling edge so the launching edge has settled
  task chk_irq(input logic e);
    begin
      @(negedge clk) cmp("irq", {15'h0, e}, {15'h0, irq});
      @(posedge clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    rst = 1'b1;
    ls = 16'h0000;
    page = 1'b0;
    ev = 5'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    i_host.rd_reg(5'h11, rv);
    cmp("status reset", 16'h0002, rv);
    i_host.rd_reg(5'h12, rv);
    cmp("enable reset", 16'h0000, rv);
    for (i = 0; i < 4; i = i + 1) begin
      ls <= {i[1:0], pat[i]};
      repeat (2) @(posedge clk);
      i_host.rd_reg(5'h11, rv);
      cmp("status", qs({i[1:0], pat[i]}), rv);
    end
    page <= 1'b1;
    @(posedge clk);
    page <= 1'b0;
    i_host.rd_reg(5'h11, rv);
    cmp("page set", qs(ls) | 16'h1000, rv);
    i_host.rd_reg(5'h11, rv);
    cmp("page cleared", qs(ls), rv);
    i_host.wr_reg(5'h12, 16'hFFFF);
    i_host.rd_reg(5'h12, rv);
    cmp("enable mask", 16'hFD7F, rv);
    i_host.wr_reg(5'h11, 16'hFFFF);
    i_host.rd_reg(5'h11, rv);
    cmp("status read only", qs(ls), rv);
    i_host.wr_reg(5'h1F, 16'hFFFF);
    i_host.rd_reg(5'h1F, rv);
    cmp("unmapped", 16'h0000, rv);
    i_host.wr_reg(5'h12, 16'h0000);
    i_host.rd_burst(5'h11, 3);
    i_host.wr_reg(5'h13, 16'hFFFF);
    for (i = 0; i < 5; i = i + 1) begin
      b = eb[i];
      @(posedge clk);
      i_host.wr_reg(5'h12, 16'hFD7F & ~(16'h1 << b));
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      i_host.rd_reg(5'h13, rv);
      cmp("event status", 16'h1 << b, rv);
      chk_irq(1'b0);
      i_host.wr_reg(5'h12, 16'h1 << b);
      chk_irq(1'b1);
      i_host.wr_reg(5'h13, 16'h1 << b);
      chk_irq(1'b0);
    end
    // Level changes latch events; falls of resolved and jabber must not
    ls   <= 16'h1000;
    page <= 1'b1;
    @(posedge clk);
    page <= 1'b0;
    @(posedge clk);
    i_host.rd_reg(5'h13, rv);
    cmp("change events", 16'h7452, rv);
    i_host.wr_reg(5'h13, 16'hFFFF);
    @(posedge clk);
    i_host.wr_reg(5'h12, 16'h0800);
    ls <= 16'h1801;
    @(posedge clk);
    chk_irq(1'b1);
    i_host.rd_reg(5'h13, rv);
    cmp("rise events", 16'h0801, rv);
    print_verdict;
  end
endmodule // phy_status_and_irq_enable_tb
